// [hw/sc_scaler.sv]
// Purpose: Memory-to-memory horizontal and vertical image scaler for one component.
// Assumes: APB register access; byte-wide memory master with req/ack handshake.
// Notes: Engine reads a seven-word parameter table from memory on start.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps

// Overview of operation
// - Five-tap filter, phase taken from the scaling counter fraction.
// - Horizontal mode fetches input, stores output, one line per pass.
// - Horizontal taps beyond the line ends are mirrored back inside.
// - Start addresses are byte addresses without alignment.
// - Line start advances by a signed 16-bit offset; negative flips.
// - Heights and widths are unsigned 16-bit counts.
// - Scaling counter loads the signed start fraction at each line.
// - Control bit 15 outputs the nearest input pixel unfiltered.
// - Bit 9 clear: filter sees nearest pixel and two neighbours each side.
// - Bit 9 set: side taps are pixels nearest the neighbouring outputs.
// - Bit 9 set forces the filter phase to zero.
// - Vertical mode uses a separate line counter as scaling phase.
// - Vertical taps above and below the image are mirrored.
// - Vertical mode works in 64-pixel columns, top to bottom.
// - Buffered segments are reused; usually one new fetch per output.
// - Six 64-pixel buffers: five feed the filter, one is filled.
// - Vertical bypass passes the nearest input line unfiltered.
module sc_scaler (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sc_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Memory master
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [sc_pkg::PIX_W-1:0] mem_wdata,
	input wire logic [sc_pkg::PIX_W-1:0] mem_rdata,
	input wire logic mem_ack
);
	import sc_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE, S_TBL, S_LINE, S_PIX, S_FETCH, S_FILT, S_WR, S_VCHK, S_VFILL, S_VPIX, S_DONE
	} sc_fsm_t;

	typedef struct packed {
		sc_fsm_t fsm;
		logic busy;
		logic done;
		logic vert;
		logic [31:0] tptr;
		logic [4:0] bcnt;
		logic [6:0][31:0] tbl;
		logic [15:0] oy;
		logic [15:0] ox;
		logic [15:0] col;
		logic signed [31:0] pos;
		logic signed [31:0] vpos;
		logic [2:0] k;
		logic [NTAPS-1:0][PIX_W-1:0] taps;
		logic [NBUF-1:0][16:0] tags;
		logic [NTAPS-1:0][BUF_W-1:0] map;
		logic [BUF_W-1:0] fbuf;
		logic [15:0] fline;
		logic [15:0] fi;
		logic mem_req;
		logic mem_we;
		logic [31:0] mem_addr;
		logic [PIX_W-1:0] mem_wdata;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} sc_state_t;

	sc_state_t st;
	sc_state_t next_st;
	sc_if s();

	logic start;
	logic done_clr;
	logic mem_done;
	logic [31:0] in_base;
	logic [31:0] out_base;
	logic [15:0] in_off;
	logic [15:0] out_off;
	logic [15:0] sfrac;
	logic signed [31:0] sfrac_ext;
	logic signed [31:0] inc;
	logic [15:0] in_w;
	logic [15:0] in_h;
	logic [15:0] out_w;
	logic [15:0] out_h;
	logic bypass;
	logic spread;
	logic [15:0] segw;
	logic [15:0] htap;
	logic [NTAPS-1:0][15:0] need;
	logic [NTAPS-1:0] hit;
	logic [NTAPS-1:0][BUF_W-1:0] hitbuf;
	logic [NBUF-1:0] used;
	logic [BUF_W-1:0] victim;
	logic [15:0] miss_line;

	// ==========================================
	// Address and tap arithmetic
	function automatic logic [31:0] addr_of(input logic [31:0] base, input logic [15:0] off,
			input logic [15:0] line, input logic [15:0] x);
		logic signed [31:0] prod;
		prod = $signed({16'h0000, line}) * $signed(32'($signed(off)));
		return base + prod + {16'h0000, x};
	endfunction

	function automatic logic [15:0] tap_index(input logic signed [31:0] p, input logic signed [31:0] step,
			input logic [2:0] k, input logic wide, input logic [15:0] n);
		logic signed [31:0] rel;
		logic signed [31:0] c;
		logic signed [31:0] lim;
		rel = $signed({29'h0000_0000, k}) - TAP_MID;
		if (wide)
			c = (p + rel * step + HALF) >>> FRAC_W;
		else
			c = ((p + HALF) >>> FRAC_W) + rel;
		lim = $signed({16'h0000, n}) - ONE_IDX;
		if (c < 0)
			c = -c;
		if (c > lim)
			c = lim - (c - lim);
		if (c < 0)
			c = 32'sh0000_0000;
		return c[15:0];
	endfunction

	function automatic logic [PH_W-1:0] phase_of(input logic signed [31:0] p);
		logic signed [31:0] d;
		d = p - (((p + HALF) >>> FRAC_W) <<< FRAC_W);
		return d[FRAC_W-1 -: PH_W];
	endfunction

	// ==========================================
	// Parameter table fields
	assign in_base = st.tbl[TW_IN_ADDR];
	assign in_off = st.tbl[TW_IN_OFF][0 +: HALF_W];
	assign sfrac = st.tbl[TW_IN_OFF][HALF_W +: HALF_W];
	assign sfrac_ext = 32'($signed(sfrac));
	assign inc = $signed(st.tbl[TW_INC]);
	assign in_w = st.tbl[TW_IN_SIZE][0 +: HALF_W];
	assign in_h = st.tbl[TW_IN_SIZE][HALF_W +: HALF_W];
	assign out_base = st.tbl[TW_OUT_ADDR];
	assign out_off = st.tbl[TW_CTRL][0 +: HALF_W];
	assign bypass = st.tbl[TW_CTRL][HALF_W + CW_BYPASS];
	assign spread = st.tbl[TW_CTRL][HALF_W + CW_SPREAD];
	assign out_w = st.tbl[TW_OUT_SIZE][0 +: HALF_W];
	assign out_h = st.tbl[TW_OUT_SIZE][HALF_W +: HALF_W];
	assign segw = ((out_w - st.col) > SEG_LEN) ? SEG_LEN : (out_w - st.col);
	assign htap = tap_index(st.pos, inc, st.k, spread, in_w);

	// ==========================================
	// Vertical segment lookup
	for (genvar k = 0; k < NTAPS; k++) begin : g_need
		assign need[k] = tap_index(st.vpos, inc, 3'(k), spread, in_h);
	end

	always_comb begin
		hit = '0;
		hitbuf = '0;
		used = '0;
		victim = '0;
		miss_line = '0;
		for (int k = NTAPS - 1; k >= 0; k--) begin
			for (int b = NBUF - 1; b >= 0; b--) begin
				if (st.tags[b][TAG_V] && st.tags[b][15:0] == need[k]) begin
					hit[k] = 1'b1;
					hitbuf[k] = 3'(b);
					used[b] = 1'b1;
				end
			end
			if (!hit[k])
				miss_line = need[k];
		end
		for (int b = NBUF - 1; b >= 0; b--) begin
			if (!used[b])
				victim = 3'(b);
		end
	end

	// ==========================================
	// Filter and buffer hookup
	assign s.taps = st.vert ? s.rd_data : st.taps;
	assign s.bypass = bypass;
	assign s.phase = spread ? '0 : phase_of(st.vert ? st.vpos : st.pos);
	assign s.wr_en = (st.fsm == S_VFILL) && mem_done;
	assign s.wr_buf = st.fbuf;
	assign s.wr_idx = st.fi[IDX_W-1:0];
	assign s.wr_data = mem_rdata;
	assign s.rd_buf = st.map;
	assign s.rd_idx = st.ox[IDX_W-1:0];

	sc_tap_filter sc_tap_filter_inst (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.f(s.flt)
	);

	sc_seg_buf sc_seg_buf_inst (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.b(s.sbuf)
	);

	// ==========================================
	// Next state
	always_comb begin
		next_st = st;
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		start = 1'b0;
		done_clr = 1'b0;
		mem_done = st.mem_req && mem_ack;
		if (psel && penable && !st.pready) begin
			next_st.pready = 1'b1;
			next_st.prdata = 32'h0000_0000;
			case (paddr)
				REG_CTRL: next_st.prdata[CTRL_VERT] = st.vert;
				REG_STATUS: begin
					next_st.prdata[STAT_BUSY] = st.busy;
					next_st.prdata[STAT_DONE] = st.done;
				end
				REG_TABLE: next_st.prdata = st.tptr;
				REG_PROGRESS: next_st.prdata = {st.col, st.oy};
				default: next_st.pslverr = 1'b1;
			endcase
		end
		if (psel && penable && st.pready && pwrite) begin
			case (paddr)
				REG_CTRL: begin
					if (!st.busy) begin
						next_st.vert = pwdata[CTRL_VERT];
						start = pwdata[CTRL_START];
					end
				end
				REG_STATUS: done_clr = pwdata[STAT_DONE];
				REG_TABLE: begin
					if (!st.busy)
						next_st.tptr = pwdata;
				end
				default: ;
			endcase
		end
		if (done_clr)
			next_st.done = 1'b0;
		case (st.fsm)
			S_IDLE: begin
				if (start) begin
					next_st.busy = 1'b1;
					next_st.bcnt = '0;
					next_st.mem_req = 1'b1;
					next_st.mem_we = 1'b0;
					next_st.mem_addr = st.tptr;
					next_st.fsm = S_TBL;
				end
			end
			S_TBL: begin
				if (mem_done) begin
					next_st.tbl[st.bcnt[4:2]][{st.bcnt[1:0], 3'h0} +: PIX_W] = mem_rdata;
					next_st.bcnt = st.bcnt + 5'h01;
					next_st.mem_addr = st.mem_addr + 32'h0000_0001;
					if (st.bcnt == TBL_LAST) begin
						next_st.mem_req = 1'b0;
						next_st.oy = '0;
						next_st.col = '0;
						next_st.tags = '0;
						next_st.vpos = 32'($signed(next_st.tbl[TW_IN_OFF][HALF_W +: HALF_W]));
						next_st.fsm = S_LINE;
					end
				end
			end
			S_LINE: begin
				if (!st.vert) begin
					if (st.oy >= out_h || out_w == '0) begin
						next_st.fsm = S_DONE;
					end else begin
						next_st.pos = sfrac_ext;
						next_st.ox = '0;
						next_st.k = '0;
						next_st.fsm = S_PIX;
					end
				end else if (st.col >= out_w || out_h == '0) begin
					next_st.fsm = S_DONE;
				end else if (st.oy >= out_h) begin
					next_st.col = st.col + SEG_LEN;
					next_st.oy = '0;
					next_st.vpos = sfrac_ext;
					next_st.tags = '0;
				end else begin
					next_st.ox = '0;
					next_st.fsm = S_VCHK;
				end
			end
			S_PIX: begin
				if (st.ox >= out_w) begin
					next_st.oy = st.oy + 16'h0001;
					next_st.fsm = S_LINE;
				end else if (st.k == TAP_COUNT) begin
					next_st.fsm = S_FILT;
				end else begin
					next_st.mem_req = 1'b1;
					next_st.mem_we = 1'b0;
					next_st.mem_addr = addr_of(in_base, in_off, st.oy, htap);
					next_st.fsm = S_FETCH;
				end
			end
			S_FETCH: begin
				if (mem_done) begin
					next_st.mem_req = 1'b0;
					next_st.taps[st.k] = mem_rdata;
					next_st.k = st.k + 3'h1;
					next_st.fsm = S_PIX;
				end
			end
			S_FILT: begin
				next_st.mem_req = 1'b1;
				next_st.mem_we = 1'b1;
				next_st.mem_wdata = s.result;
				next_st.mem_addr = addr_of(out_base, out_off, st.oy, st.vert ? st.col + st.ox : st.ox);
				next_st.fsm = S_WR;
			end
			S_WR: begin
				if (mem_done) begin
					next_st.mem_req = 1'b0;
					next_st.mem_we = 1'b0;
					if (!st.vert) begin
						next_st.ox = st.ox + 16'h0001;
						next_st.pos = st.pos + inc;
						next_st.k = '0;
						next_st.fsm = S_PIX;
					end else if (st.ox + 16'h0001 >= segw) begin
						next_st.oy = st.oy + 16'h0001;
						next_st.vpos = st.vpos + inc;
						next_st.fsm = S_LINE;
					end else begin
						next_st.ox = st.ox + 16'h0001;
						next_st.fsm = S_VPIX;
					end
				end
			end
			S_VCHK: begin
				if (&hit) begin
					next_st.map = hitbuf;
					next_st.fsm = S_VPIX;
				end else begin
					next_st.tags[victim] = '0;
					next_st.fbuf = victim;
					next_st.fline = miss_line;
					next_st.fi = '0;
					next_st.mem_req = 1'b1;
					next_st.mem_we = 1'b0;
					next_st.mem_addr = addr_of(in_base, in_off, miss_line, st.col);
					next_st.fsm = S_VFILL;
				end
			end
			S_VFILL: begin
				if (mem_done) begin
					if (st.fi + 16'h0001 >= segw) begin
						next_st.mem_req = 1'b0;
						next_st.tags[st.fbuf] = {1'b1, st.fline};
						next_st.fsm = S_VCHK;
					end else begin
						next_st.fi = st.fi + 16'h0001;
						next_st.mem_addr = st.mem_addr + 32'h0000_0001;
					end
				end
			end
			S_VPIX: next_st.fsm = S_FILT;
			S_DONE: begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
				next_st.fsm = S_IDLE;
			end
			default: next_st.fsm = S_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign mem_req = st.mem_req;
	assign mem_we = st.mem_we;
	assign mem_addr = st.mem_addr;
	assign mem_wdata = st.mem_wdata;

	// ==========================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_done_end: assert property (ce && st.fsm == S_DONE |=> st.done && !st.busy && st.fsm == S_IDLE)
		else $error("completion not flagged after last line");
	chk_wide_phase: assert property (spread |-> s.phase == '0)
		else $error("phase not zero with wide spread pick");
	chk_line_load: assert property (ce && st.fsm == S_LINE && !st.vert && st.oy < out_h && out_w != '0
		|=> st.pos == sfrac_ext && st.ox == '0)
		else $error("scaling counter not loaded at line start");
	chk_pixel_step: assert property (ce && st.fsm == S_WR && mem_done && !st.vert
		|=> st.pos == $past(st.pos) + $past(inc))
		else $error("scaling counter did not step by increment");
	chk_tap_inside: assert property (st.fsm == S_PIX && st.k < TAP_COUNT && in_w != '0 |-> htap < in_w)
		else $error("horizontal tap outside the line");
	chk_vtap_inside: assert property (st.vert && in_h != '0 |-> need[0] < in_h && need[4] < in_h)
		else $error("vertical tap outside the image");
	chk_req_hold: assert property (ce && st.mem_req && !mem_ack |=> st.mem_req && $stable(st.mem_addr))
		else $error("memory request dropped before acknowledge");
	chk_victim_free: assert property (st.fsm == S_VFILL |-> !st.tags[st.fbuf][TAG_V])
		else $error("buffer in use is being refilled");
	chk_col_width: assert property (st.vert && st.fsm == S_WR |-> st.ox < SEG_LEN)
		else $error("vertical write outside the column");
	chk_bypass_path: assert property (ce && st.fsm == S_VPIX && bypass
		|=> st.fsm == S_FILT && s.result == $past(s.rd_data[2]))
		else $error("vertical bypass did not pass the centre line");
endmodule // sc_scaler

// [hw/sc_pkg.sv]
// Purpose: Shared constants for the memory-to-memory image scaler filter.
// Assumes: 32-bit APB register bus, byte-wide memory master port.
// Notes: Register offsets are byte addresses within the block.
package sc_pkg;
	// ==========================================
	// Register map
	localparam int unsigned APB_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TABLE = 8'h08;
	localparam logic [7:0] REG_PROGRESS = 8'h0C;
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_VERT = 1;
	localparam int unsigned STAT_BUSY = 0;
	localparam int unsigned STAT_DONE = 1;
	// ==========================================
	// Parameter table layout, one 32-bit word each
	localparam logic [4:0] TBL_LAST = 5'h1B;
	localparam int unsigned TW_IN_ADDR = 0;
	localparam int unsigned TW_IN_OFF = 1;
	localparam int unsigned TW_INC = 2;
	localparam int unsigned TW_IN_SIZE = 3;
	localparam int unsigned TW_OUT_ADDR = 4;
	localparam int unsigned TW_CTRL = 5;
	localparam int unsigned TW_OUT_SIZE = 6;
	localparam int unsigned HALF_W = 16;
	localparam int unsigned CW_BYPASS = 15;
	localparam int unsigned CW_SPREAD = 9;
	// ==========================================
	// Scaling arithmetic, 16.16 fixed point
	localparam int unsigned FRAC_W = 16;
	localparam logic signed [31:0] HALF = 32'sh0000_8000;
	localparam logic signed [31:0] ONE_IDX = 32'sh0000_0001;
	localparam logic signed [31:0] TAP_MID = 32'sh0000_0002;
	// ==========================================
	// Filter and segment buffers
	localparam int unsigned NTAPS = 5;
	localparam logic [2:0] TAP_COUNT = 3'h5;
	localparam int unsigned NBUF = 6;
	localparam int unsigned SEG_PIX = 64;
	localparam logic [15:0] SEG_LEN = 16'h0040;
	localparam int unsigned PIX_W = 8;
	localparam int unsigned IDX_W = 6;
	localparam int unsigned BUF_W = 3;
	localparam int unsigned PH_W = 3;
	localparam int unsigned TAG_V = 16;
	localparam logic [3:0] W_EDGE = 4'h1;
	localparam logic [3:0] W_NEAR = 4'h4;
	localparam logic [3:0] W_MID = 4'h6;
	localparam int unsigned SUM_SHIFT = 4;
endpackage

// [hw/sc_if.sv]
// Purpose: Carrier between the scaler engine, its filter and its segment buffers.
// Assumes: All signals in the engine clock domain.
// Notes: Tap 2 is the centre tap.
`timescale 1ns/1ps
interface sc_if;
	import sc_pkg::*;
	logic [NTAPS-1:0][PIX_W-1:0] taps;
	logic signed [PH_W-1:0] phase;
	logic bypass;
	logic [PIX_W-1:0] result;
	logic wr_en;
	logic [BUF_W-1:0] wr_buf;
	logic [IDX_W-1:0] wr_idx;
	logic [PIX_W-1:0] wr_data;
	logic [NTAPS-1:0][BUF_W-1:0] rd_buf;
	logic [IDX_W-1:0] rd_idx;
	logic [NTAPS-1:0][PIX_W-1:0] rd_data;
	modport flt (input taps, input phase, input bypass, output result);
	modport sbuf (input wr_en, input wr_buf, input wr_idx, input wr_data, input rd_buf, input rd_idx,
		output rd_data);
endinterface

// [hw/sc_seg_buf.sv]
// Purpose: Six 64-pixel input segment buffers for vertical scaling.
// Assumes: One write port, five read ports addressed by buffer and pixel index.
// Notes: Reads are combinational from flip-flops.
`timescale 1ns/1ps
module sc_seg_buf (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Buffer ports
	sc_if.sbuf b
);
	import sc_pkg::*;

	typedef struct packed {
		logic [NBUF-1:0][SEG_PIX-1:0][PIX_W-1:0] mem;
	} sc_buf_t;

	sc_buf_t st;
	sc_buf_t next_st;

	always_comb begin
		next_st = st;
		if (b.wr_en && b.wr_buf < BUF_W'(NBUF)) begin
			next_st.mem[b.wr_buf][b.wr_idx] = b.wr_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// ==========================================
	// One read port per filter tap
	for (genvar k = 0; k < NTAPS; k++) begin : g_rd
		assign b.rd_data[k] = (b.rd_buf[k] < BUF_W'(NBUF)) ? st.mem[b.rd_buf[k]][b.rd_idx] : '0;
	end
endmodule // sc_seg_buf

// [hw/sc_tap_filter.sv]
// Purpose: Five-tap phase-steered filter with bypass, one register stage.
// Assumes: Phase is a signed eighth-pixel offset from the centre tap.
// Notes: Weights always sum to sixteen.
`timescale 1ns/1ps
module sc_tap_filter (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Taps in, result out
	sc_if.flt f
);
	import sc_pkg::*;

	typedef struct packed {
		logic [PIX_W-1:0] result;
	} sc_filt_t;

	sc_filt_t st;
	sc_filt_t next_st;
	logic [4:0] ph;
	logic [NTAPS-1:0][4:0] w;
	logic [NTAPS-1:0][12:0] prod;
	logic [12:0] sum;

	// ==========================================
	// Weights steered by phase
	assign ph = {{2{f.phase[PH_W-1]}}, f.phase};
	assign w[0] = {1'b0, W_EDGE};
	assign w[1] = {1'b0, W_NEAR} - ph;
	assign w[2] = {1'b0, W_MID};
	assign w[3] = {1'b0, W_NEAR} + ph;
	assign w[4] = {1'b0, W_EDGE};

	for (genvar i = 0; i < NTAPS; i++) begin : g_tap
		assign prod[i] = {5'h00, f.taps[i]} * {8'h00, w[i]};
	end
	assign sum = prod[0] + prod[1] + prod[2] + prod[3] + prod[4];

	always_comb begin
		next_st = st;
		if (f.bypass) begin
			next_st.result = f.taps[2];
		end else begin
			next_st.result = sum[SUM_SHIFT +: PIX_W];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign f.result = st.result;

	chk_bypass_centre: assert property (@(posedge pclk) disable iff (!presetn)
		ce && f.bypass |=> f.result == $past(f.taps[2]))
		else $error("bypass result is not the centre tap");
endmodule // sc_tap_filter

// [verif/sc_mem_model.sv]
// Purpose: Byte-wide main memory that answers the scaler's memory master port.
// Assumes: Request held until acknowledged; acknowledge comes after a random wait.
// Notes: The bench loads image and table bytes straight into the array.
`timescale 1ns/1ps
module sc_mem_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Memory slave
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	output logic mem_ack
);
	logic [7:0] mem [int unsigned];
	int seed = 40875;
	// ==========================================
	// One-cycle acknowledge; data is only meaningful alongside it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack <= 1'b0;
			mem_rdata <= 8'h00;
		end else if (mem_req && !mem_ack && ($random(seed) & 1)) begin
			mem_ack <= 1'b1;
			mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 8'hA5;
		end else begin
			if (mem_req && mem_ack && mem_we)
				mem[mem_addr] = mem_wdata;
			mem_ack <= 1'b0;
			// Stale data is inverted so a late sample cannot pass by luck
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule // sc_mem_model

// [verif/sc_scaler_tb.sv]
// Purpose: Self-checking bench for the scaler: block copy, picking, filtering, vertical copy, registers.
// Assumes: Four horizontal runs and one vertical bypass run, two lines, unity or double step.
// Notes: Pixel writes and APB answers are checked from queues by monitors; image bytes are random.
`timescale 1ns/1ps
module sc_scaler_tb;
	import sc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, mem_addr;
	logic pready, pslverr, mem_req, mem_we, mem_ack;
	logic [7:0] mem_wdata, mem_rdata;
	logic [39:0] exp_px[$];
	logic [33:0] exp_reg[$];
	int errors = 0, n_compared = 0, cyc = 0, seed = 40875;
	logic [31:0] rd;
	logic [7:0] img[96];
	logic [15:0] ctl[5] = '{16'h8000, 16'h8000, 16'h0000, 16'h0200, 16'h8000};
	logic [15:0] stp[5] = '{16'h0001, 16'h0002, 16'h0001, 16'h0002, 16'h0001};
	logic [15:0] ow[5] = '{16'h0004, 16'h0002, 16'h0004, 16'h0002, 16'h0004};
	// ==========================================
	// Clock, design and memory
	always #20 pclk = ~pclk;
	sc_scaler sc_scaler_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
	sc_mem_model sc_mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
	// ==========================================
	// Checking
	task automatic cmp_px(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_reg(input logic [32:0] got, input logic [33:0] exp);
		n_compared++;
		if (got[32] !== exp[32] || (exp[33] && got[31:0] !== exp[31:0])) begin
			errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp[32:0]);
		end
	endtask
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge pclk) begin
		if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_we === 1'b1) begin
			if (exp_px.size() == 0)
				cmp_px({mem_addr, mem_wdata}, 40'h0);
			else
				cmp_px({mem_addr, mem_wdata}, exp_px.pop_front());
		end
		if (pready === 1'b1 && exp_reg.size() != 0)
			cmp_reg({pslverr, prdata}, exp_reg.pop_front());
		cyc++;
		if (cyc == 60000) begin
			errors++;
			close_out();
		end
	end
	// ==========================================
	// APB master; entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] ex);
		exp_reg.push_back(ex);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Reference pixel: weights 1, 4-s, 6, 4+s, 1 over sixteen, s the phase in eighths
	function automatic logic [7:0] ref_px(input int i, input int x, input int y);
		int c;
		int s;
		int step;
		int acc;
		step = stp[i];
		s = ctl[i][CW_SPREAD] ? 0 : -2;
		acc = 0;
		for (int k = 0; k < NTAPS; k++) begin
			c = ctl[i][CW_SPREAD] ? (x + k - 2) * step : x * step + k - 2;
			if (c < 0)
				c = -c;
			if (c > 3)
				c = 6 - c;
			acc += img[16 - 16 * y + c] * ((k == 2) ? 6 : (k == 1) ? 4 - s : (k == 3) ? 4 + s : 1);
		end
		if (i == 4)
			return img[16 + 64 * y + x];
		if (ctl[i][CW_BYPASS])
			return img[16 - 16 * y + x * step];
		return acc[11:4];
	endfunction
	task automatic put_word(input int a, input logic [31:0] v);
		for (int b = 0; b < 4; b++)
			sc_mem_model_inst.mem[a + b] = v[8*b +: 8];
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h10, 32'h0, {2'b11, 32'h0});
		apb(1'b1, REG_TABLE, 32'h0000_0100, {2'b00, 32'h0});
		apb(1'b0, REG_TABLE, 32'h0, {2'b10, 32'h0000_0100});
		for (int i = 0; i < 5; i++) begin
			for (int a = 0; a < 96; a++) begin
				img[a] = 8'($random(seed));
				sc_mem_model_inst.mem[32'h0000_1000 + a] = img[a];
			end
			// Horizontal input flipped (line 1 sits 16 bytes below line 0); vertical lines 64 bytes apart
			put_word(32'h100, 32'h0000_1010);
			put_word(32'h104, (i == 4) ? 32'hC000_0040 : 32'hC000_FFF0);
			put_word(32'h108, {stp[i], 16'h0000});
			put_word(32'h10C, 32'h0002_0004);
			put_word(32'h110, 32'h0000_2003);
			put_word(32'h114, {ctl[i], 16'h0008});
			put_word(32'h118, {16'h0002, ow[i]});
			for (int y = 0; y < 2; y++)
				for (int x = 0; x < ow[i]; x++)
					exp_px.push_back({32'h2003 + 8 * y + x, ref_px(i, x, y)});
			apb(1'b1, REG_CTRL, (i == 4) ? 32'h0000_0003 : 32'h0000_0001, {2'b00, 32'h0});
			apb(1'b1, REG_TABLE, 32'h0000_0200, {2'b00, 32'h0});
			rd = 32'h1;
			while (rd[STAT_BUSY] !== 1'b0)
				apb(1'b0, REG_STATUS, 32'h0, {2'b00, 32'h0});
			apb(1'b0, REG_TABLE, 32'h0, {2'b10, 32'h0000_0100});
			apb(1'b0, REG_STATUS, 32'h0, {2'b10, 32'h0000_0002});
			apb(1'b1, REG_STATUS, 32'h0000_0002, {2'b00, 32'h0});
			apb(1'b0, REG_STATUS, 32'h0, {2'b10, 32'h0000_0000});
			apb(1'b0, REG_CTRL, 32'h0, {2'b10, (i == 4) ? 32'h0000_0002 : 32'h0000_0000});
			apb(1'b0, REG_PROGRESS, 32'h0, {2'b10, (i == 4) ? 32'h0040_0000 : 32'h0000_0002});
			cmp_px({39'h0, exp_px.size() == 0}, 40'h1);
			$display("test %0d done", i);
		end
		close_out();
	end
endmodule // sc_scaler_tb
